// ==== bench/rpvm_chk.sv ====
// assertions on the rx port monitor register group
// assumes the bind below attaches it to rpvm_top
`timescale 1ns/100ps
module rpvm_chk #(
	parameter FW = 8
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_rdata,
	input wire reg_hit,
	input wire meas_vld,
	input wire pkt_len_err,
	input wire pkt_payload_checksum_fault_flag,
	input wire pkt_multi_bit_header_fault_flag,
	input wire pkt_single_bit_header_fault_flag,
	input wire [31:0] hdr_in,
	input wire [31:0] hdr_out,
	input wire [FW-1:0] freq_held_mhz,
	input wire freq_stable,
	input wire [3:0] csi_err_flags
);
	wire [3:0] errs = {pkt_len_err, pkt_payload_checksum_fault_flag, pkt_multi_bit_header_fault_flag, pkt_single_bit_header_fault_flag};
	wire sts_rd = reg_rd && reg_addr == 8'h7a;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	err_set_a: assert property (1'b1 |=> (csi_err_flags & $past(errs)) == $past(errs))
		else $error("flag not set by bad packet");
	flag_hold_a: assert property (!sts_rd |=>
		(csi_err_flags & $past(csi_err_flags)) == $past(csi_err_flags)) else $error("flag lost");
	read_clr_a: assert property (sts_rd && errs == 4'h0 |=> csi_err_flags == 4'h0)
		else $error("flags not cleared by read");
	sts_top_a: assert property (sts_rd |=> reg_rdata[7:4] == 4'h0)
		else $error("status upper bits set");
	held_src_a: assert property (!$past(sys_rst) && $changed(freq_held_mhz) |-> $past(meas_vld))
		else $error("held frequency moved alone");
	settle_min_a: assert property ($changed(freq_held_mhz) |=> !freq_stable [*7])
		else $error("stable too early");
	unmap_rd_a: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	hdr_fix_a: assert property (!$past(sys_rst) |-> $countones(hdr_out ^ $past(hdr_in)) <= 1)
		else $error("header altered in more than one bit");
	cover property (sts_rd && csi_err_flags != 4'h0);
	cover property ($rose(freq_stable));
	cover property (reg_rd && reg_addr == 8'h75);
	cover property (hdr_out != $past(hdr_in));
endmodule
bind rpvm_top rpvm_chk #(.FW(FW)) i_chk (.sys_clk, .sys_rst, .reg_rd, .reg_addr, .reg_rdata,
	.reg_hit, .meas_vld, .pkt_len_err, .pkt_payload_checksum_fault_flag, .pkt_multi_bit_header_fault_flag, .pkt_single_bit_header_fault_flag, .hdr_in,
	.hdr_out, .freq_held_mhz, .freq_stable, .csi_err_flags);

// ==== bench/rpvm_top_bench.sv ====
// self-checking bench for rpvm_top
// assumes settle counts of 8, 16, 32 and 64 cycles
`timescale 1ns/100ps
module rpvm_top_bench;
	logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, meas_vld = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, meas_mhz = 8'h00;
	logic line_size_change_irq_enable = 1'b0, pkt_len_err = 1'b0, pkt_payload_checksum_fault_flag = 1'b0;
	logic pkt_multi_bit_header_fault_flag = 1'b0, pkt_single_bit_header_fault_flag = 1'b0;
	logic [31:0] hdr_in = 32'h00000000;
	wire [7:0] reg_rdata, freq_held_mhz;
	wire [31:0] hdr_out;
	wire [15:0] line_len;
	wire [3:0] csi_err_flags;
	wire reg_hit, line_end, frame_end, freq_stable, freq_too_low;
	int fail_count = 0, cmp_count = 0, n;
	rpvm_vid_src i_src (.sys_clk, .line_end, .line_len, .frame_end);
	rpvm_top #(.FW(8), .SETTLE_CYC0(18'd8), .SETTLE_CYC1(18'd16), .SETTLE_CYC2(18'd32),
		.SETTLE_CYC3(18'd64)) i_dut (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_hit, .line_size_change_irq_enable, .line_end, .line_len, .frame_end,
		.meas_vld, .meas_mhz, .pkt_len_err, .pkt_payload_checksum_fault_flag, .pkt_multi_bit_header_fault_flag, .pkt_single_bit_header_fault_flag,
		.hdr_in, .hdr_out, .freq_held_mhz, .freq_stable, .freq_too_low, .csi_err_flags);
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(posedge sys_clk);
		// the bench stands for a host that has already steered the port select here
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		#1 chk(reg_rdata, e);
	endtask
	task perr(input [3:0] e);
		@(posedge sys_clk);
		{pkt_len_err, pkt_payload_checksum_fault_flag, pkt_multi_bit_header_fault_flag, pkt_single_bit_header_fault_flag} <= e;
		@(posedge sys_clk);
		{pkt_len_err, pkt_payload_checksum_fault_flag, pkt_multi_bit_header_fault_flag, pkt_single_bit_header_fault_flag} <= 4'h0;
	endtask
	task meas(input [7:0] v);
		@(posedge sys_clk);
		meas_vld <= 1'b1;
		meas_mhz <= v;
		@(posedge sys_clk);
		meas_vld <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task t_regs;
		for (int i = 0; i < 7; i++)
			rd(8'(8'h74 + i), 8'(56'h000100c5000000 >> (8 * i)));
		wr(8'h78, 8'ha5);
		wr(8'h79, 8'h5a);
		wr(8'h75, 8'hff);
		wr(8'h7a, 8'hff);
		rd(8'h78, 8'ha5);
		rd(8'h79, 8'h5a);
		rd(8'h75, 8'h00);
		rd(8'h7a, 8'h00);
		$display("test regs done");
	endtask
	task t_line;
		i_src.frame(16'h1234, 16'h0abc);
		rd(8'h75, 8'h0a);
		i_src.frame(16'h1122, 16'h1122);
		rd(8'h76, 8'hbc);
		rd(8'h75, 8'h11);
		rd(8'h76, 8'h22);
		@(posedge sys_clk);
		line_size_change_irq_enable <= 1'b1;
		i_src.frame(16'h0333, 16'h0333);
		i_src.frame(16'h0444, 16'h0444);
		rd(8'h75, 8'h03);
		rd(8'h76, 8'h33);
		i_src.frame(16'h0555, 16'h0555);
		rd(8'h75, 8'h05);
		@(posedge sys_clk);
		line_size_change_irq_enable <= 1'b0;
		$display("test line done");
	endtask
	task t_freq;
		for (int s = 0; s < 4; s++) begin
			wr(8'h77, {2'b00, 2'(s), 4'h5});
			@(posedge sys_clk);
			meas_vld <= 1'b1;
			meas_mhz <= 8'(32 + 16 * s);
			@(posedge sys_clk);
			meas_vld <= 1'b0;
			n = 0;
			do begin
				@(posedge sys_clk);
				#1 n++;
			end while (freq_stable !== 1'b1 && n < 200);
			if (n == 200) begin
				fail_count++;
				report_and_stop;
			end
			chk(n >= (8 << s) - 1 && n <= (8 << s) + 2, 1);
		end
		wr(8'h77, 8'hc5);
		meas(8'h53);
		chk(freq_held_mhz, 8'h50);
		meas(8'h54);
		chk(freq_held_mhz, 8'h54);
		chk(freq_stable, 1'b0);
		meas(8'h03);
		chk(freq_too_low, 1'b1);
		meas(8'h09);
		meas(8'h05);
		chk({freq_held_mhz, freq_too_low}, 9'h00a);
		$display("test freq done");
	endtask
	task t_csi;
		for (int k = 0; k < 4; k++) begin
			perr(4'(1 << k));
			rd(8'h7a, 8'(1 << k));
			rd(8'h7a, 8'h00);
		end
		perr(4'h4);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= 8'h7a;
		pkt_len_err <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		pkt_len_err <= 1'b0;
		@(posedge sys_clk);
		#1 chk(reg_rdata, 8'h04);
		rd(8'h7a, 8'h08);
		$display("test csi done");
	endtask
	// the all-zero header is a valid codeword: one flipped bit must come back as zero,
	// a two-bit flip must pass untouched
	task t_hdr;
		for (int k = 0; k < 31; k++) begin
			@(posedge sys_clk);
			hdr_in <= (k < 30) ? 32'h1 << k : 32'h00000003;
			@(posedge sys_clk);
			#1 chk(hdr_out, (k < 30) ? 32'h00000000 : 32'h00000003);
		end
		$display("test hdr done");
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_regs;
		t_line;
		t_freq;
		t_csi;
		t_hdr;
		report_and_stop;
	end
endmodule

// ==== bench/rpvm_vid_src.sv ====
// video line source in place of the remote serializer
// assumes the bench calls frame from its own process
`timescale 1ns/100ps
module rpvm_vid_src (
	input wire sys_clk,
	output logic line_end = 1'b0,
	output logic [15:0] line_len = 16'h0000,
	output logic frame_end = 1'b0
);
	task automatic frame(input [15:0] a, input [15:0] b);
		@(posedge sys_clk);
		line_end <= 1'b1;
		line_len <= a;
		@(posedge sys_clk);
		line_len <= b;
		frame_end <= 1'b1;
		@(posedge sys_clk);
		line_end <= 1'b0;
		frame_end <= 1'b0;
		// idle bus must not keep showing the last length
		line_len <= ~b;
	endtask
endmodule

// ==== rtl/rpvm_freq_det.v ====
// clock frequency monitor: deadband capture, settle timer, low floor compare
// assumes meas_vld pulses with a fresh whole-MHz measurement of the link clock
`timescale 1ns/100ps
`include "rpvm_regs.vh"
module rpvm_freq_det #(
	parameter FW = 8,
	parameter [17:0] SETTLE_CYC0 = `RPVM_SETTLE_US0 * `RPVM_CLK_MHZ,
	parameter [17:0] SETTLE_CYC1 = `RPVM_SETTLE_US1 * `RPVM_CLK_MHZ,
	parameter [17:0] SETTLE_CYC2 = `RPVM_SETTLE_US2 * `RPVM_CLK_MHZ,
	parameter [17:0] SETTLE_CYC3 = `RPVM_SETTLE_US3 * `RPVM_CLK_MHZ
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire meas_vld,
	input wire [FW-1:0] meas_mhz,
	input wire [1:0] frequency_deadband,
	input wire [1:0] frequency_settle_time_select,
	input wire [3:0] frequency_floor_mhz,
	output wire [FW-1:0] freq_held_mhz,
	output wire freq_stable,
	output wire freq_too_low
);
	reg [FW-1:0] held_r;
	reg [17:0] tmr_r;
	reg stable_r;
	wire [FW-1:0] diff;
	wire outside;
	reg [17:0] limit;

	assign diff = (meas_mhz > held_r) ? meas_mhz - held_r : held_r - meas_mhz;
	assign outside = meas_vld && (diff > {{(FW-2){1'b0}}, frequency_deadband});

	always @* begin
		case (frequency_settle_time_select)
		2'b00: limit = SETTLE_CYC0;
		2'b01: limit = SETTLE_CYC1;
		2'b10: limit = SETTLE_CYC2;
		default: limit = SETTLE_CYC3;
		endcase
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			held_r <= {FW{1'b0}};
			tmr_r <= 18'h00000;
			stable_r <= 1'b0;
		end else if (outside) begin
			held_r <= meas_mhz;
			tmr_r <= 18'h00000;
			stable_r <= 1'b0;
		end else if (tmr_r + 18'h00001 >= limit) begin
			stable_r <= 1'b1;
		end else begin
			tmr_r <= tmr_r + 18'h00001;
		end
	end

	assign freq_held_mhz = held_r;
	assign freq_stable = stable_r;
	// floor compare against the held value so jitter inside the deadband cannot toggle it
	assign freq_too_low = held_r < {{(FW-4){1'b0}}, frequency_floor_mhz};
endmodule

// ==== rtl/rpvm_line_len.v ====
// line length capture with freeze and coherent high/low byte read
// assumes line_end pulses once per line with line_len valid, frame_end once per frame
`timescale 1ns/100ps
`include "rpvm_regs.vh"
module rpvm_line_len #(
	parameter W = 16
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire line_end,
	input wire [W-1:0] line_len,
	input wire frame_end,
	input wire freeze_en,
	input wire rd_hi,
	input wire rd_lo,
	output wire [7:0] line_size_upper_byte,
	output wire [7:0] line_size_lower_byte
);
	reg [W-1:0] last_r;
	reg [W-1:0] rep_r;
	reg [7:0] lo_snap_r;
	reg snap_vld_r;
	reg frozen_r;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			last_r <= `RPVM_RST_LINE;
			rep_r <= `RPVM_RST_LINE;
			lo_snap_r <= 8'h00;
			snap_vld_r <= 1'b0;
			frozen_r <= 1'b0;
		end else begin
			// the latest line overwrites, so the frame's final line survives
			if (line_end)
				last_r <= line_len;
			if (frame_end && !frozen_r) begin
				rep_r <= line_end ? line_len : last_r;
				// a freeze holds until software reads the value
				if (freeze_en)
					frozen_r <= 1'b1;
			end
			if (rd_hi) begin
				lo_snap_r <= rep_r[7:0];
				snap_vld_r <= 1'b1;
			end else if (rd_lo) begin
				snap_vld_r <= 1'b0;
			end
			if ((rd_hi || rd_lo) && !(frame_end && freeze_en && !frozen_r))
				frozen_r <= 1'b0;
		end
	end

	assign line_size_upper_byte = rep_r[15:8];
	assign line_size_lower_byte = snap_vld_r ? lo_snap_r : rep_r[7:0];
endmodule

// ==== rtl/rpvm_regs.vh ====
// register offsets, field positions, reset values and timing counts of the rx port monitor
// assumes an 8-bit register address space reached through the serial control port
`ifndef RPVM_REGS_VH
`define RPVM_REGS_VH

`define RPVM_ADDR_LINE_HI 8'h75
`define RPVM_ADDR_LINE_LO 8'h76
`define RPVM_ADDR_FREQ_CTL 8'h77
`define RPVM_ADDR_MBOX_A 8'h78
`define RPVM_ADDR_MBOX_B 8'h79
`define RPVM_ADDR_CSI_STS 8'h7a

`define RPVM_RST_LINE 16'h0000
`define RPVM_RST_FREQ_CTL 8'hc5
`define RPVM_RST_MBOX_A 8'h00
`define RPVM_RST_MBOX_B 8'h01
`define RPVM_RST_CSI_STS 4'h0

`define RPVM_HYST_HI 7
`define RPVM_HYST_LO 6
`define RPVM_SETTLE_HI 5
`define RPVM_SETTLE_LO 4
`define RPVM_FLOOR_HI 3
`define RPVM_FLOOR_LO 0

`define RPVM_STS_LEN 3
`define RPVM_STS_CKSUM 2
`define RPVM_STS_ECC2 1
`define RPVM_STS_ECC1 0

// settle times in microseconds, clock in MHz
`define RPVM_CLK_MHZ 125
`define RPVM_SETTLE_US0 40
`define RPVM_SETTLE_US1 80
`define RPVM_SETTLE_US2 320
`define RPVM_SETTLE_US3 1280

`endif

// ==== rtl/rpvm_top.v ====
// rx port video monitor register group: line length, frequency detect, mailboxes, csi errors,
// and single-bit repair of the forwarded packet header
// assumes a serial-control front end that presents one-cycle rd/wr strobes for this port only
// Behaviour
// - the latest frame's 16-bit line length reads as a read-only high and low byte, reset zero.
// - when line length varies in a frame the final line's length is reported.
// - with the line-length-change interrupt enable set the value freezes until read.
// - reading the high byte snapshots the low byte so the next low read is consistent.
// - a new frequency is captured only if it differs from the held one by more than the deadband.
// - the clock counts stable after staying in band for 40 us, 80 us, 320 us or 1.28 ms.
// - the held frequency is compared to a 4-bit floor in MHz to flag a too slow clock.
// - two 8-bit read/write mailbox registers with no hardware effect, the second resets to 0x01.
// - status bit 3 sets on a packet whose header length does not match its payload.
// - status bit 2 sets on a payload checksum failure.
// - status bit 1 sets on a multi-bit header ecc error, which is not corrected.
// - status bit 0 sets on a single-bit header ecc error, which is corrected.
// - error flags stay set until the status register is read, bits 7:4 read zero.
`timescale 1ns/100ps
`include "rpvm_regs.vh"
module rpvm_top #(
	parameter FW = 8,
	parameter [17:0] SETTLE_CYC0 = `RPVM_SETTLE_US0 * `RPVM_CLK_MHZ,
	parameter [17:0] SETTLE_CYC1 = `RPVM_SETTLE_US1 * `RPVM_CLK_MHZ,
	parameter [17:0] SETTLE_CYC2 = `RPVM_SETTLE_US2 * `RPVM_CLK_MHZ,
	parameter [17:0] SETTLE_CYC3 = `RPVM_SETTLE_US3 * `RPVM_CLK_MHZ
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output wire reg_hit,
	input wire line_size_change_irq_enable,
	input wire line_end,
	input wire [15:0] line_len,
	input wire frame_end,
	input wire meas_vld,
	input wire [FW-1:0] meas_mhz,
	input wire pkt_len_err,
	input wire pkt_payload_checksum_fault_flag,
	input wire pkt_multi_bit_header_fault_flag,
	input wire pkt_single_bit_header_fault_flag,
	input wire [31:0] hdr_in,
	output reg [31:0] hdr_out,
	output wire [FW-1:0] freq_held_mhz,
	output wire freq_stable,
	output wire freq_too_low,
	output wire [3:0] csi_err_flags
);
	reg [7:0] freq_ctl_r;
	reg [7:0] mbox_a_r;
	reg [7:0] mbox_b_r;
	reg [3:0] sts_r;
	wire [7:0] line_hi;
	wire [7:0] line_lo;
	wire rd_hi;
	wire rd_lo;
	wire rd_sts;
	wire [3:0] sts_set;
	reg [7:0] rdata_nxt;

	// decodes one register offset; shared by read and write paths
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// reached only after the host has steered the port select to this port
	assign rd_hi = reg_rd && hit(reg_addr, `RPVM_ADDR_LINE_HI);
	assign rd_lo = reg_rd && hit(reg_addr, `RPVM_ADDR_LINE_LO);
	assign rd_sts = reg_rd && hit(reg_addr, `RPVM_ADDR_CSI_STS);
	assign reg_hit = (reg_addr >= `RPVM_ADDR_LINE_HI) && (reg_addr <= `RPVM_ADDR_CSI_STS);

	rpvm_line_len #(
		.W(16)
	) u_line (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.line_end(line_end),
		.line_len(line_len),
		.frame_end(frame_end),
		.freeze_en(line_size_change_irq_enable),
		.rd_hi(rd_hi),
		.rd_lo(rd_lo),
		.line_size_upper_byte(line_hi),
		.line_size_lower_byte(line_lo)
	);

	rpvm_freq_det #(
		.FW(FW),
		.SETTLE_CYC0(SETTLE_CYC0),
		.SETTLE_CYC1(SETTLE_CYC1),
		.SETTLE_CYC2(SETTLE_CYC2),
		.SETTLE_CYC3(SETTLE_CYC3)
	) u_freq (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.meas_vld(meas_vld),
		.meas_mhz(meas_mhz),
		.frequency_deadband(freq_ctl_r[`RPVM_HYST_HI:`RPVM_HYST_LO]),
		.frequency_settle_time_select(freq_ctl_r[`RPVM_SETTLE_HI:`RPVM_SETTLE_LO]),
		.frequency_floor_mhz(freq_ctl_r[`RPVM_FLOOR_HI:`RPVM_FLOOR_LO]),
		.freq_held_mhz(freq_held_mhz),
		.freq_stable(freq_stable),
		.freq_too_low(freq_too_low)
	);

	assign sts_set[`RPVM_STS_LEN] = pkt_len_err;
	assign sts_set[`RPVM_STS_CKSUM] = pkt_payload_checksum_fault_flag;
	assign sts_set[`RPVM_STS_ECC2] = pkt_multi_bit_header_fault_flag;
	assign sts_set[`RPVM_STS_ECC1] = pkt_single_bit_header_fault_flag;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			freq_ctl_r <= `RPVM_RST_FREQ_CTL;
			mbox_a_r <= `RPVM_RST_MBOX_A;
			mbox_b_r <= `RPVM_RST_MBOX_B;
			sts_r <= `RPVM_RST_CSI_STS;
		end else begin
			if (reg_wr && hit(reg_addr, `RPVM_ADDR_FREQ_CTL))
				freq_ctl_r <= reg_wdata;
			if (reg_wr && hit(reg_addr, `RPVM_ADDR_MBOX_A))
				mbox_a_r <= reg_wdata;
			if (reg_wr && hit(reg_addr, `RPVM_ADDR_MBOX_B))
				mbox_b_r <= reg_wdata;
			// a new error in the read cycle survives the clear
			sts_r <= (rd_sts ? 4'h0 : sts_r) | sts_set;
		end
	end

	// header layout: [23:0] data, [29:24] check bits, [31:30] reserved and passed as is
	// check-bit column of one data bit; every column has odd weight, so a single flip gives
	// an odd syndrome and any double flip an even one that matches no column
	function [5:0] ecc_col;
		input [4:0] idx;
		begin
			case (idx)
			5'd0: ecc_col = 6'h07;
			5'd1: ecc_col = 6'h0b;
			5'd2: ecc_col = 6'h0d;
			5'd3: ecc_col = 6'h0e;
			5'd4: ecc_col = 6'h13;
			5'd5: ecc_col = 6'h15;
			5'd6: ecc_col = 6'h16;
			5'd7: ecc_col = 6'h19;
			5'd8: ecc_col = 6'h1a;
			5'd9: ecc_col = 6'h1c;
			5'd10: ecc_col = 6'h23;
			5'd11: ecc_col = 6'h25;
			5'd12: ecc_col = 6'h26;
			5'd13: ecc_col = 6'h29;
			5'd14: ecc_col = 6'h2a;
			5'd15: ecc_col = 6'h2c;
			5'd16: ecc_col = 6'h31;
			5'd17: ecc_col = 6'h32;
			5'd18: ecc_col = 6'h34;
			5'd19: ecc_col = 6'h38;
			5'd20: ecc_col = 6'h1f;
			5'd21: ecc_col = 6'h2f;
			5'd22: ecc_col = 6'h37;
			5'd23: ecc_col = 6'h3b;
			default: ecc_col = 6'h00;
			endcase
		end
	endfunction

	function [5:0] ecc_calc;
		input [23:0] d;
		integer i;
		begin
			ecc_calc = 6'h00;
			for (i = 0; i < 24; i = i + 1) begin
				if (d[i])
					ecc_calc = ecc_calc ^ ecc_col(i[4:0]);
			end
		end
	endfunction

	reg [5:0] hdr_syn;
	reg [31:0] hdr_fix;
	integer b;

	// the error flags stay with the packet checker's strobes; this path only repairs the
	// header that is forwarded, so a flag and a repair of one packet need not share a cycle
	always @* begin
		hdr_syn = ecc_calc(hdr_in[23:0]) ^ hdr_in[29:24];
		hdr_fix = hdr_in;
		for (b = 0; b < 24; b = b + 1) begin
			if (hdr_syn == ecc_col(b[4:0]))
				hdr_fix[b] = ~hdr_in[b];
		end
		// a lone syndrome bit points at a flipped check bit
		for (b = 0; b < 6; b = b + 1) begin
			if (hdr_syn == (6'h01 << b))
				hdr_fix[24 + b] = ~hdr_in[24 + b];
		end
	end

	// an even syndrome matches nothing above, so double-bit errors pass unchanged
	always @(posedge sys_clk) begin
		if (sys_rst)
			hdr_out <= 32'h00000000;
		else
			hdr_out <= hdr_fix;
	end

	always @* begin
		case (reg_addr)
		`RPVM_ADDR_LINE_HI: rdata_nxt = line_hi;
		`RPVM_ADDR_LINE_LO: rdata_nxt = line_lo;
		`RPVM_ADDR_FREQ_CTL: rdata_nxt = freq_ctl_r;
		`RPVM_ADDR_MBOX_A: rdata_nxt = mbox_a_r;
		`RPVM_ADDR_MBOX_B: rdata_nxt = mbox_b_r;
		`RPVM_ADDR_CSI_STS: rdata_nxt = {4'h0, sts_r};
		default: rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge sys_clk) begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
	end

	assign csi_err_flags = sts_r;
endmodule
